// ==== inc/csw_defines.svh ====
// Constants for the crate safety watchdog
`ifndef CSW_DEFINES_SVH
`define CSW_DEFINES_SVH
`define CSW_PARAM_W 2
`define CSW_PARAM_DISABLE 2'h0
`define CSW_PARAM_ENABLE 2'h1
`define CSW_PARAM_CLEAR 2'h2
`define CSW_CLK_HZ 250000000
`define CSW_MS_PER_S 1000
`define CSW_TIMEOUT_MS 3000
`define CSW_SHUTDOWN_MS 5000
`define CSW_RESET_PULSE_CYC 16
`define CSW_CNT_W 32
`endif

// ==== inc/csw_pkg.sv ====
// Types shared by the crate safety watchdog
package csw_pkg;
  typedef struct packed {
    logic valid;
    logic [1:0] param;
  } csw_cmd_s;
  typedef enum logic [1:0] {
    CSW_OFF = 2'b00,
    CSW_ARMED = 2'b01,
    CSW_SHUTDOWN = 2'b10,
    CSW_RESET = 2'b11
  } csw_state_e;
endpackage

// ==== src/csw_sync.sv ====
// Two-flop synchroniser for one level
`timescale 1ns/1ps
module csw_sync (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta_reg;
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_reg <= 1'b0;
      q_o <= 1'b0;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule

// ==== src/csw_watchdog.sv ====
// Crate safety watchdog: command decode, timeout, shutdown and crate reset
//
// Overview of operation
// - Parameter 0 disables, 1 enables, 2 clears.
// - Expiry starts shutdown rather than immediate reset.
// - Wait mirror shutdown time, then reset crate.
// - Shutdown signal on backplane precedes crate reset.
`timescale 1ns/1ps
`include "csw_defines.svh"
module csw_watchdog #(
  parameter int unsigned TIMEOUT_CYC = (`CSW_CLK_HZ / `CSW_MS_PER_S) * `CSW_TIMEOUT_MS,
  parameter int unsigned SHUTDOWN_CYC = (`CSW_CLK_HZ / `CSW_MS_PER_S) * `CSW_SHUTDOWN_MS,
  parameter int unsigned RESET_CYC = `CSW_RESET_PULSE_CYC
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire csw_pkg::csw_cmd_s cmd_i,
  output logic enabled_o,
  output logic expired_o,
  output logic shutdown_o,
  output logic crate_rst_o
);
  import csw_pkg::*;

  // ****************************************
  // Parameter checks
  // ****************************************
  // Shorter phases leave no cycle between start and end of a count,
  // and the backplane signal must stand long enough for the boards to see it
  if (TIMEOUT_CYC < 2 || SHUTDOWN_CYC < 2 || RESET_CYC < 1 ||
      SHUTDOWN_CYC + RESET_CYC < 8) begin : g_bad_counts
    $error("csw_watchdog: counts too small");
  end

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_sync_n;
  csw_sync u_rst_sync (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .d_i(1'b1),
    .q_o(rst_sync_n)
  );

  // ****************************************
  // Command decode
  // ****************************************
  function automatic logic is_param(input csw_cmd_s c, input logic [1:0] p);
    return c.valid && (c.param == p);
  endfunction

  logic cmd_dis, cmd_en, cmd_clr;
  assign cmd_dis = is_param(cmd_i, `CSW_PARAM_DISABLE);
  assign cmd_en = is_param(cmd_i, `CSW_PARAM_ENABLE);
  assign cmd_clr = is_param(cmd_i, `CSW_PARAM_CLEAR);

  // ****************************************
  // Sequencer
  // ****************************************
  csw_state_e state_reg;
  logic [`CSW_CNT_W-1:0] cnt_reg;
  localparam logic [`CSW_CNT_W-1:0] TO_LAST = `CSW_CNT_W'(TIMEOUT_CYC - 1);
  localparam logic [`CSW_CNT_W-1:0] SD_LAST = `CSW_CNT_W'(SHUTDOWN_CYC - 1);
  localparam logic [`CSW_CNT_W-1:0] RS_LAST = `CSW_CNT_W'(RESET_CYC - 1);

  // Once shutdown begins no command can cancel it: a half-stopped mirror is unsafe
  always_ff @(posedge clk_sys_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_reg <= CSW_OFF;
      cnt_reg <= '0;
    end else begin
      unique case (state_reg)
        CSW_OFF: begin
          cnt_reg <= '0;
          if (cmd_en) begin
            state_reg <= CSW_ARMED;
          end
        end
        CSW_ARMED: begin
          if (cmd_dis) begin
            state_reg <= CSW_OFF;
            cnt_reg <= '0;
          end else if (cmd_en || cmd_clr) begin
            cnt_reg <= '0;
          end else if (cnt_reg == TO_LAST) begin
            state_reg <= CSW_SHUTDOWN;
            cnt_reg <= '0;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        CSW_SHUTDOWN: begin
          if (cnt_reg == SD_LAST) begin
            state_reg <= CSW_RESET;
            cnt_reg <= '0;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        CSW_RESET: begin
          // Crate reset also clears this block via the reset pin in a real crate
          if (cnt_reg == RS_LAST) begin
            state_reg <= CSW_OFF;
            cnt_reg <= '0;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
      endcase
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      enabled_o <= 1'b0;
      expired_o <= 1'b0;
      shutdown_o <= 1'b0;
      crate_rst_o <= 1'b0;
    end else begin
      enabled_o <= (state_reg == CSW_ARMED);
      expired_o <= (state_reg == CSW_SHUTDOWN) || (state_reg == CSW_RESET);
      shutdown_o <= (state_reg == CSW_SHUTDOWN) || (state_reg == CSW_RESET);
      crate_rst_o <= (state_reg == CSW_RESET);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_reset_after_shutdown: assert property (
    @(posedge clk_sys_i) disable iff (!rst_sync_n)
    $rose(crate_rst_o) |-> $past(shutdown_o))
    else $error("crate reset without prior shutdown");

  a_shutdown_holds: assert property (
    @(posedge clk_sys_i) disable iff (!rst_sync_n)
    $rose(shutdown_o) |-> shutdown_o [*8])
    else $error("shutdown dropped early");

  a_expiry_when_due: assert property (
    @(posedge clk_sys_i) disable iff (!rst_sync_n)
    (state_reg == CSW_ARMED && cnt_reg == TO_LAST && !cmd_i.valid)
      |=> state_reg == CSW_SHUTDOWN ##1 shutdown_o)
    else $error("expiry did not start shutdown");

  a_clear_restarts: assert property (
    @(posedge clk_sys_i) disable iff (!rst_sync_n)
    (state_reg == CSW_ARMED && (cmd_clr || cmd_en)) |=> cnt_reg == '0)
    else $error("clear did not restart interval");

  a_disable_stops: assert property (
    @(posedge clk_sys_i) disable iff (!rst_sync_n)
    (state_reg == CSW_ARMED && cmd_dis) |=> state_reg == CSW_OFF ##1 !enabled_o)
    else $error("disable command ignored");

  a_enable_arms: assert property (
    @(posedge clk_sys_i) disable iff (!rst_sync_n)
    (state_reg == CSW_OFF && cmd_en) |=> ##1 enabled_o)
    else $error("enable command ignored");

  a_off_no_expiry: assert property (
    @(posedge clk_sys_i) disable iff (!rst_sync_n)
    (state_reg == CSW_OFF && !cmd_en) |=> state_reg == CSW_OFF)
    else $error("disabled watchdog expired");

  a_reset_pulse_ends: assert property (
    @(posedge clk_sys_i) disable iff (!rst_sync_n)
    (state_reg == CSW_RESET && cnt_reg == RS_LAST) |=> ##1 !crate_rst_o && !shutdown_o)
    else $error("crate reset pulse did not end");

  // Unknown codes such as parameter 3 must neither restart nor stall the interval
  a_armed_counts_up: assert property (
    @(posedge clk_sys_i) disable iff (!rst_sync_n)
    (state_reg == CSW_ARMED && !(cmd_dis || cmd_en || cmd_clr) && cnt_reg != TO_LAST)
      |=> state_reg == CSW_ARMED && cnt_reg == $past(cnt_reg) + 1'b1)
    else $error("armed interval did not advance");

  a_interval_bounded: assert property (
    @(posedge clk_sys_i) disable iff (!rst_sync_n)
    state_reg == CSW_ARMED |-> cnt_reg <= TO_LAST)
    else $error("armed counter ran past the timeout");

  // Commands arriving during shutdown must not cancel it
  a_shutdown_locked: assert property (
    @(posedge clk_sys_i) disable iff (!rst_sync_n)
    (state_reg == CSW_SHUTDOWN && cnt_reg != SD_LAST) |=> state_reg == CSW_SHUTDOWN)
    else $error("shutdown phase left early");

  a_shutdown_to_reset: assert property (
    @(posedge clk_sys_i) disable iff (!rst_sync_n)
    (state_reg == CSW_SHUTDOWN && cnt_reg == SD_LAST) |=> state_reg == CSW_RESET ##1 crate_rst_o)
    else $error("crate reset did not follow shutdown time");

  a_backplane_driven: assert property (
    @(posedge clk_sys_i) disable iff (!rst_sync_n)
    state_reg == CSW_SHUTDOWN |=> shutdown_o && expired_o && !enabled_o)
    else $error("backplane shutdown not driven");

  a_reset_under_shutdown: assert property (
    @(posedge clk_sys_i) disable iff (!rst_sync_n)
    crate_rst_o |-> shutdown_o)
    else $error("crate reset without backplane shutdown");
endmodule

// ==== verif/csw_host_model.sv ====
// Supervisory host model issuing watchdog commands
`timescale 1ns/1ps
module csw_host_model (
  input wire logic clk_sys_i,
  output csw_pkg::csw_cmd_s cmd_o
);
  import csw_pkg::*;
  initial cmd_o = '0;
  // host sends commands
  // Param is inverted when idle so nothing leans on a stale code
  task automatic send(input logic [1:0] p);
    @(negedge clk_sys_i);
    cmd_o = '{valid: 1'b1, param: p};
    @(negedge clk_sys_i);
    cmd_o = '{valid: 1'b0, param: ~p};
  endtask
endmodule

// ==== verif/testbench.sv ====
// Self-checking bench for the crate safety watchdog
`timescale 1ns/1ps
module testbench;
  import csw_pkg::*;
  localparam int TO = 20;
  localparam int SD = 30;
  localparam int RP = 4;
  logic clk_sys_i, nrst_i, enabled_o, expired_o, shutdown_o, crate_rst_o;
  csw_cmd_s cmd;
  int mismatches = 0;
  int checks_done = 0;
  int n;
  csw_host_model u_csw_host_model (.clk_sys_i(clk_sys_i), .cmd_o(cmd));
  csw_watchdog #(.TIMEOUT_CYC(TO), .SHUTDOWN_CYC(SD), .RESET_CYC(RP)) u_csw_watchdog (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .cmd_i(cmd), .enabled_o(enabled_o),
    .expired_o(expired_o), .shutdown_o(shutdown_o), .crate_rst_o(crate_rst_o));
  // ****************
  // Helpers
  // ****************
  function automatic logic [3:0] outs();
    return {enabled_o, expired_o, shutdown_o, crate_rst_o};
  endfunction
  task automatic report_and_stop();
    if (mismatches == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [3:0] exp, input string m);
    checks_done++;
    if (outs() !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic chk_n(input int got, input int lo, input int hi, input string m);
    checks_done++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  // Bounded wait for one output bit; 3 armed, 2 expired, 1 shutdown, 0 crate reset
  task automatic wait_out(input int b, input logic v, output int k);
    logic [3:0] o;
    k = 0;
    o = outs();
    while (o[b] !== v) begin
      if (k > 200) begin
        mismatches++;
        report_and_stop();
      end
      @(negedge clk_sys_i);
      k++;
      o = outs();
    end
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_idle();
    chk(4'h0, "outputs after reset");
    u_csw_host_model.send(2'h2);
    u_csw_host_model.send(2'h0);
    u_csw_host_model.send(2'h3);
    repeat (3) @(negedge clk_sys_i);
    chk(4'h0, "armed without enable");
  endtask
  task automatic t_toggle();
    u_csw_host_model.send(2'h1);
    repeat (2) @(negedge clk_sys_i);
    chk(4'h8, "enable");
    u_csw_host_model.send(2'h3);
    repeat (2) @(negedge clk_sys_i);
    chk(4'h8, "code 3 acted");
    u_csw_host_model.send(2'h0);
    repeat (2) @(negedge clk_sys_i);
    chk(4'h0, "disable");
  endtask
  task automatic t_kick();
    u_csw_host_model.send(2'h1);
    repeat (5) begin
      repeat (TO - 6) @(negedge clk_sys_i);
      u_csw_host_model.send(2'h2);
    end
    repeat (TO - 6) @(negedge clk_sys_i);
    u_csw_host_model.send(2'h1);
    chk(4'h8, "expired despite clears");
  endtask
  task automatic t_expire();
    wait_out(1, 1'b1, n);
    chk_n(n, TO - 1, TO + 3, "timeout length");
    chk(4'h6, "shutdown before reset");
    u_csw_host_model.send(2'h0);
    u_csw_host_model.send(2'h2);
    wait_out(0, 1'b1, n);
    chk_n(n + 4, SD - 1, SD + 1, "shutdown delay");
    chk(4'h7, "crate reset phase");
    wait_out(0, 1'b0, n);
    chk_n(n, RP, RP, "reset pulse width");
    chk(4'h0, "off after crate reset");
  endtask
  task automatic t_reset_mid();
    u_csw_host_model.send(2'h1);
    repeat (2) @(negedge clk_sys_i);
    chk(4'h8, "enable after crate reset");
    nrst_i = 1'b0;
    @(negedge clk_sys_i);
    chk(4'h0, "reset in mid-run");
    nrst_i = 1'b1;
    repeat (TO + 10) @(negedge clk_sys_i);
    chk(4'h0, "expiry while disabled");
    u_csw_host_model.send(2'h1);
    repeat (2) @(negedge clk_sys_i);
    chk(4'h8, "enable after mid-run reset");
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    nrst_i = 1'b0;
    repeat (20) @(negedge clk_sys_i);
    nrst_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    t_idle();
    t_toggle();
    t_kick();
    t_expire();
    t_reset_mid();
    report_and_stop();
  end
endmodule
